// File: verilog/wake_pkg.sv
// constants and types shared by the wakeup and interrupt-enable block
package wake_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] PB_WAKE_MASK_IDX = 8'hc0; // port_b_wake_mask
    localparam logic [7:0] IRQ_FLAGS_IDX = 8'hc8; // irq_request_flags
    localparam logic [7:0] IRQ_EN_IDX = 8'hc9; // interrupt_enable_bits
    localparam logic [7:0] MODE_CTRL_IDX = 8'hca; // mode request bits
    localparam logic [7:0] OSC_CFG_IDX = 8'hcb; // oscillator type
    localparam logic [7:0] STACK_PTR_IDX = 8'hdf; // stack_pointer_reg

    // ****************************************************************
    // widths, field positions and reset values
    // ****************************************************************
    localparam int PB_W = 7; // port b pins with wake function
    localparam logic [6:0] PB_WAKE_MASK_RST = 7'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
    localparam logic [7:0] IRQ_BITS_MASK = 8'h73; // implemented bits
    localparam int EXT_A_BIT = 0;
    localparam int EXT_B_BIT = 1;
    localparam int WAKE_TMR_BIT = 4;
    localparam int CNT_TMR_BIT = 5;
    localparam int SEC_TMR_BIT = 6;
    localparam int GIE_BIT = 7;
    localparam logic GIE_RST = 1'b0;
    localparam logic [2:0] STACK_PTR_RST = 3'h7;
    localparam int SLEEP_REQ_BIT = 0;
    localparam int IDLE_REQ_BIT = 1;
    localparam int SLOW_SEL_BIT = 2;
    localparam int PC_W = 12;
    localparam logic [11:0] IRQ_VECTOR_PC = 12'h008;

    // ****************************************************************
    // warm-up lengths in oscillator periods
    // ****************************************************************
    localparam int WARM_W = 16;
    localparam logic [15:0] WARM_HX_CNT = 16'h0a00; // 2560 high clocks
    localparam logic [15:0] WARM_RC_CNT = 16'h0020; // 32 periods
    localparam logic [15:0] WARM_IH_RC_CNT = 16'h0120; // 288 low clocks
    localparam int WARM_LX_CNT_DEF = 16640; // 2^14 + 256 low clocks

    // oscillator configuration
    typedef enum logic [2:0] {
        OSC_HX = 3'b000, // external high-speed crystal
        OSC_RC = 3'b001, // external rc, high or low speed
        OSC_LX = 3'b010, // external low-speed crystal
        OSC_IH_LRC = 3'b011, // internal high osc, low osc is rc
        OSC_IH_LX = 3'b100 // internal high osc, low osc is crystal
    } osc_type_t;

    // power state
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_SLOW = 3'b001,
        ST_SLEEP = 3'b010,
        ST_IDLE = 3'b011,
        ST_WARMUP = 3'b100
    } pwr_state_t;

endpackage

// File: verilog/sync_2ff.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q; // first stage, read only by the second

    // ****************************************************************
    // two stages
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: verilog/warmup_counter.sv
// warm-up counter: counts ticks while running, flags the terminal count
`timescale 1ns/100ps
`default_nettype none
module warmup_counter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] len,
    output logic done
);
    logic [W-1:0] count_q; // periods counted so far
    logic [W-1:0] count_d;

    // next count: cleared while stopped, saturates at the length
    always_comb begin
        count_d = count_q;
        if (!run) begin
            count_d = '0;
        end else if (tick && count_q != len) begin
            count_d = count_q + W'(1);
        end
    end

    // register the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // terminal count reached
    assign done = run && (count_q == len);
endmodule
`default_nettype wire

// File: verilog/wake_irq_ctrl.sv
// wakeup, warm-up timing and interrupt enable logic with ahb-lite registers
//
// Contract
// - sleep wakes only on pin change, to normal
// - idle wakes on pins or timer, previous mode
// - idle wakeup resumes with no warm-up
// - high crystal waits 2560 high clocks
// - rc oscillator waits 32 periods
// - low crystal waits 2^14+256 low clocks
// - internal oscillator counts 288 or 2^14+256 low
// - any enabled pin level change wakes
// - port a always wakes, port b masked
// - port b mask write-only, bits 6:0, zero
// - five sources, three timers, two pins
// - pin request stays latched through warm-up
// - taking interrupt clears global enable
// - return from interrupt sets global enable
// - taking interrupt adds stack level, vector 8
// - enable bits 0,1,4,5,6, reset zero
// - request flags set regardless of enables
// - request bits self-clear on wakeup
// - no interrupt without global enable, bit 7
`timescale 1ns/100ps
`default_nettype none
module wake_irq_ctrl
    import wake_pkg::*;
#(
    parameter int PA_W = 8,
    parameter int unsigned WARM_LX_CNT = WARM_LX_CNT_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [PA_W-1:0] port_a_pin,
    input wire logic [PB_W-1:0] port_b_pin,
    input wire logic osc_running_pin,
    input wire logic low_clk_pin,
    input wire logic wake_timer_ovf,
    input wire logic counter_timer_ovf,
    input wire logic second_timer_ovf,
    input wire logic cpu_irq_take,
    input wire logic cpu_return_from_irq,
    output logic cpu_run,
    output logic cpu_slow,
    output logic irq_pending,
    output logic pc_load,
    output logic [PC_W-1:0] pc_vector
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [PA_W+PB_W+1:0] sync_q; // all asynchronous pins, synced
    logic [PA_W-1:0] pa_s; // port a levels
    logic [PB_W-1:0] pb_s; // port b levels
    logic osc_ok_s; // selected oscillator produces edges
    logic lclk_s; // low clock level

    sync_2ff #(.W(PA_W + PB_W + 2)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({low_clk_pin, osc_running_pin, port_b_pin, port_a_pin}),
        .q(sync_q)
    );
    assign {lclk_s, osc_ok_s, pb_s, pa_s} = sync_q;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [6:0] pb_mask_q, pb_mask_d; // port_b_pin_wake_enable bits
    logic [7:0] irq_en_q, irq_en_d; // interrupt_enable_bits
    logic [7:0] irq_flag_q, irq_flag_d; // irq_request_flags
    logic gie_q, gie_d; // global_irq_enable
    logic [2:0] stk_q, stk_d; // stack level pointer
    logic sleep_req_q, sleep_req_d; // sleep_request_bit
    logic idle_req_q, idle_req_d; // idle_request_bit
    logic slow_q, slow_d; // slow mode selected
    osc_type_t osc_q, osc_d; // oscillator configuration
    pwr_state_t state_q, state_d; // power state
    logic [PA_W-1:0] snap_a_q, snap_a_d; // port a at mode entry
    logic [PB_W-1:0] snap_b_q, snap_b_d; // port b at mode entry
    logic [1:0] ext_prev_q; // last levels of the two irq lines
    logic lclk_prev_q; // last low clock level
    logic pc_load_q, pc_load_d; // vector load pulse

    // ****************************************************************
    // ahb-lite slave
    // ****************************************************************
    logic ap_valid; // address phase accepted this cycle
    logic addr_ok; // aligned and inside the register window
    logic [7:0] ap_idx; // register index of the address phase
    logic wr_q, wr_d; // write data phase pending
    logic [7:0] wr_idx_q, wr_idx_d; // index of that write
    logic [31:0] rdata; // read mux
    logic [31:0] hrdata_q, hrdata_d; // registered read data

    assign ap_valid = hsel && htrans[1] && hready;
    assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
    assign ap_idx = haddr[9:2];

    // read mux; write-only and unmapped words read zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (!addr_ok) begin
            rdata = 32'h0000_0000;
        end else if (ap_idx == IRQ_FLAGS_IDX) begin
            rdata = {24'h00_0000, irq_flag_q};
        end else if (ap_idx == IRQ_EN_IDX) begin
            rdata = {24'h00_0000, irq_en_q};
        end else if (ap_idx == STACK_PTR_IDX) begin
            rdata = {24'h00_0000, gie_q, 4'h0, stk_q};
        end else if (ap_idx == MODE_CTRL_IDX) begin
            rdata = {25'h000_0000, state_q, 1'b0, slow_q, idle_req_q,
                     sleep_req_q};
        end else if (ap_idx == OSC_CFG_IDX) begin
            rdata = {29'h0000_0000, osc_q};
        end
    end

    // bus phase bookkeeping
    always_comb begin
        wr_d = ap_valid && hwrite && addr_ok;
        wr_idx_d = ap_valid ? ap_idx : wr_idx_q;
        hrdata_d = (ap_valid && !hwrite) ? rdata : hrdata_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wr_idx_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_q <= wr_d;
            wr_idx_q <= wr_idx_d;
            hrdata_q <= hrdata_d;
        end
    end

    // zero wait states, always okay
    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************************************
    // wake detection and interrupt events
    // ****************************************************************
    logic [PA_W-1:0] pa_chg; // port a differs from snapshot
    logic [PB_W-1:0] pb_chg; // enabled port b differs from snapshot
    logic pin_wake; // any wake-capable pin changed
    logic [7:0] ev; // request events this cycle
    logic take; // interrupt accepted by the cpu

    assign pa_chg = pa_s ^ snap_a_q;
    assign pb_chg = (pb_s ^ snap_b_q) & pb_mask_q;
    assign pin_wake = (|pa_chg) || (|pb_chg);

    always_comb begin
        ev = 8'h00;
        ev[EXT_A_BIT] = ext_prev_q[0] & ~pa_s[0];
        ev[EXT_B_BIT] = ext_prev_q[1] & ~pa_s[1];
        ev[WAKE_TMR_BIT] = wake_timer_ovf;
        ev[CNT_TMR_BIT] = counter_timer_ovf;
        ev[SEC_TMR_BIT] = second_timer_ovf;
    end

    assign irq_pending = gie_q && cpu_run && (|(irq_flag_q & irq_en_q));
    assign take = cpu_irq_take && irq_pending;

    // ****************************************************************
    // warm-up timing
    // ****************************************************************
    logic [WARM_W-1:0] warm_len; // periods to wait
    logic warm_low; // count on the low clock
    logic warm_run; // counter enabled
    logic warm_done; // terminal count reached

    // length by oscillator type
    always_comb begin
        warm_low = 1'b1;
        warm_len = WARM_W'(WARM_LX_CNT);
        case (osc_q)
            OSC_HX: begin
                warm_low = 1'b0;
                warm_len = WARM_HX_CNT;
            end
            OSC_RC: begin
                warm_low = 1'b0;
                warm_len = WARM_RC_CNT;
            end
            OSC_IH_LRC: warm_len = WARM_IH_RC_CNT;
            default: warm_len = WARM_W'(WARM_LX_CNT);
        endcase
    end

    assign warm_run = (state_q == ST_WARMUP) && osc_ok_s;

    warmup_counter #(.W(WARM_W)) u_warm (
        .clk(hclk),
        .rst_n(hresetn),
        .run(warm_run),
        .tick(warm_low ? (lclk_s & ~lclk_prev_q) : 1'b1),
        .len(warm_len),
        .done(warm_done)
    );

    // ****************************************************************
    // registers and power state machine
    // ****************************************************************
    always_comb begin
        pb_mask_d = pb_mask_q;
        irq_en_d = irq_en_q;
        irq_flag_d = irq_flag_q;
        gie_d = gie_q;
        stk_d = stk_q;
        sleep_req_d = sleep_req_q;
        idle_req_d = idle_req_q;
        slow_d = slow_q;
        osc_d = osc_q;
        state_d = state_q;
        snap_a_d = snap_a_q;
        snap_b_d = snap_b_q;
        // software writes in the data phase
        if (wr_q) begin
            if (wr_idx_q == PB_WAKE_MASK_IDX) begin
                pb_mask_d = hwdata[6:0];
            end else if (wr_idx_q == IRQ_EN_IDX) begin
                irq_en_d = hwdata[7:0] & IRQ_BITS_MASK;
            end else if (wr_idx_q == IRQ_FLAGS_IDX) begin
                irq_flag_d = hwdata[7:0] & IRQ_BITS_MASK;
            end else if (wr_idx_q == STACK_PTR_IDX) begin
                gie_d = hwdata[GIE_BIT];
                stk_d = hwdata[2:0];
            end else if (wr_idx_q == MODE_CTRL_IDX) begin
                sleep_req_d = hwdata[SLEEP_REQ_BIT];
                idle_req_d = hwdata[IDLE_REQ_BIT];
                slow_d = hwdata[SLOW_SEL_BIT];
            end else if (wr_idx_q == OSC_CFG_IDX) begin
                osc_d = osc_type_t'(hwdata[2:0]);
            end
        end
        irq_flag_d = irq_flag_d | ev;
        if (take) begin
            gie_d = 1'b0;
            stk_d = stk_q - 3'h1;
        end else if (cpu_return_from_irq) begin
            gie_d = 1'b1;
            stk_d = stk_q + 3'h1;
        end
        case (state_q)
            ST_NORMAL, ST_SLOW: begin
                // pins tracked until the mode is left
                snap_a_d = pa_s;
                snap_b_d = pb_s;
                if (sleep_req_q) begin
                    state_d = ST_SLEEP;
                end else if (idle_req_q) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = slow_q ? ST_SLOW : ST_NORMAL;
                end
            end
            ST_SLEEP: begin
                if (pin_wake) begin
                    state_d = ST_WARMUP;
                    sleep_req_d = 1'b0;
                    slow_d = 1'b0;
                end
            end
            ST_IDLE: begin
                if (pin_wake || wake_timer_ovf) begin
                    state_d = slow_q ? ST_SLOW : ST_NORMAL;
                    idle_req_d = 1'b0;
                end
            end
            ST_WARMUP: begin
                if (warm_done) begin
                    state_d = ST_NORMAL;
                end
            end
            default: state_d = ST_NORMAL;
        endcase
        pc_load_d = take;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pb_mask_q <= PB_WAKE_MASK_RST;
            irq_en_q <= IRQ_EN_RST;
            irq_flag_q <= IRQ_FLAGS_RST;
            gie_q <= GIE_RST;
            stk_q <= STACK_PTR_RST;
            sleep_req_q <= 1'b0;
            idle_req_q <= 1'b0;
            slow_q <= 1'b0;
            osc_q <= OSC_HX;
            state_q <= ST_NORMAL;
            snap_a_q <= '0;
            snap_b_q <= '0;
            ext_prev_q <= 2'b00;
            lclk_prev_q <= 1'b0;
            pc_load_q <= 1'b0;
        end else begin
            pb_mask_q <= pb_mask_d;
            irq_en_q <= irq_en_d;
            irq_flag_q <= irq_flag_d;
            gie_q <= gie_d;
            stk_q <= stk_d;
            sleep_req_q <= sleep_req_d;
            idle_req_q <= idle_req_d;
            slow_q <= slow_d;
            osc_q <= osc_d;
            state_q <= state_d;
            snap_a_q <= snap_a_d;
            snap_b_q <= snap_b_d;
            ext_prev_q <= pa_s[1:0];
            lclk_prev_q <= lclk_s;
            pc_load_q <= pc_load_d;
        end
    end

    // cpu side
    assign cpu_run = (state_q == ST_NORMAL) || (state_q == ST_SLOW);
    assign cpu_slow = (state_q == ST_SLOW);
    assign pc_load = pc_load_q;
    assign pc_vector = IRQ_VECTOR_PC;

    // ****************************************************************
    // assertions
    // ****************************************************************
    gie_clear_a: assert property (take |=> !gie_q)
        else $error("global enable not cleared on interrupt entry");
    gie_set_a: assert property (
        cpu_return_from_irq && !take |=> gie_q)
        else $error("global enable not set on return");
    vector_load_a: assert property (
        take |=> pc_load && pc_vector == 12'h008 ##1 !pc_load)
        else $error("vector load pulse wrong");
    no_irq_gie_a: assert property (!gie_q |-> !irq_pending)
        else $error("interrupt offered without global enable");
    sleep_exit_a: assert property (
        $fell(state_q == ST_SLEEP) |-> state_q == ST_WARMUP)
        else $error("sleep left without warm-up");
    idle_resume_a: assert property (
        state_q == ST_IDLE && wake_timer_ovf
        |=> state_q == ($past(slow_q) ? ST_SLOW : ST_NORMAL))
        else $error("idle wake did not resume previous mode");
    warm_hold_a: assert property (
        state_q == ST_WARMUP |-> !cpu_run && !sleep_req_q)
        else $error("cpu runs or request kept during warm-up");
    flag_set_a: assert property (
        counter_timer_ovf |=> irq_flag_q[CNT_TMR_BIT])
        else $error("request flag not set by its event");
    mask_gate_a: assert property (
        state_q == ST_SLEEP && !(|pa_chg) && !(|pb_chg)
        && !wr_q |=> state_q == ST_SLEEP)
        else $error("sleep left without an enabled pin change");
    warm_osc_a: assert property (
        state_q == ST_WARMUP && !osc_ok_s |=> state_q == ST_WARMUP)
        else $error("warm-up ended without oscillator");
endmodule
`default_nettype wire

// File: tb/cpu_side_model.sv
// cpu core and low oscillator model facing the wakeup block
`timescale 1ns/100ps
`default_nettype none
module cpu_side_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_pending,
    input wire logic pc_load,
    input wire logic [11:0] pc_vector,
    input wire logic [1:0] take_lat,
    input wire logic ret_req,
    output logic cpu_irq_take,
    output logic cpu_return_from_irq,
    output logic low_clk_pin,
    output logic [7:0] vec_cnt
);
    // ****************************************************
    // low oscillator, free running, unrelated to hclk
    // ****************************************************
    initial begin
        low_clk_pin = 1'h0;
        forever #37 low_clk_pin = ~low_clk_pin;
    end

    // ****************************************************
    // interrupt entry after a chosen latency, and return
    // ****************************************************
    logic [3:0] wait_q; // cycles a request has waited
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_irq_take <= 1'h0;
            cpu_return_from_irq <= 1'h0;
            wait_q <= 4'h0;
            vec_cnt <= 8'h00;
        end else begin
            cpu_return_from_irq <= ret_req;
            // one take pulse once the latency has passed
            cpu_irq_take <= irq_pending && !cpu_irq_take &&
                wait_q >= {2'h0, take_lat};
            wait_q <= irq_pending ? wait_q + 4'h1 : 4'h0;
            // count vector loads to address 8 only
            if (pc_load && pc_vector == 12'h008) begin
                vec_cnt <= vec_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/test_wake_irq_ctrl.sv
// self-checking bench for the wakeup and interrupt-enable block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
    errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module test_wake_irq_ctrl;
    import wake_pkg::*;
    localparam int LX = 20; // shortened low crystal count
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, lat = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, cpu_run, cpu_slow, irq_pending, pc_load;
    logic [7:0] port_a = 8'h03, vec_cnt;
    logic [6:0] port_b = 7'h00;
    logic osc_run = 1'h1, wt = 1'h0, ct = 1'h0, st = 1'h0, ret = 1'h0;
    logic take, ret_pulse, low_clk;
    logic [11:0] pc_vector;
    logic [31:0] seed = 32'hfea319f6, r;
    int errors = 0, tests_run = 0;
    always #5 hclk = ~hclk;

    wake_irq_ctrl #(.PA_W(8), .WARM_LX_CNT(LX)) i_wake_irq_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port_a_pin(port_a),
        .port_b_pin(port_b), .osc_running_pin(osc_run),
        .low_clk_pin(low_clk), .wake_timer_ovf(wt),
        .counter_timer_ovf(ct), .second_timer_ovf(st),
        .cpu_irq_take(take), .cpu_return_from_irq(ret_pulse),
        .cpu_run(cpu_run), .cpu_slow(cpu_slow),
        .irq_pending(irq_pending), .pc_load(pc_load),
        .pc_vector(pc_vector));
    cpu_side_model i_cpu_side_model (.hclk(hclk), .hresetn(hresetn),
        .irq_pending(irq_pending), .pc_load(pc_load),
        .pc_vector(pc_vector), .take_lat(lat), .ret_req(ret),
        .cpu_irq_take(take), .cpu_return_from_irq(ret_pulse),
        .low_clk_pin(low_clk), .vec_cnt(vec_cnt));

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected warm-up in hclk cycles (low clock period 7.4)
    function automatic int warm(input int t);
        case (t)
            0: return 2560;
            1: return 32;
            3: return 288 * 74 / 10;
            default: return LX * 74 / 10;
        endcase
    endfunction
    task automatic end_of_test();
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // one bus phase: wait for hready, bounded
    task automatic phase();
        int k;
        k = 0;
        do begin @(posedge hclk); k++; end
        while (hreadyout !== 1'h1 && k < 50);
        if (k >= 50) begin errors++; end_of_test(); end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] d, output logic [31:0] q);
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'h1;
        phase();
        htrans <= 2'h0;
        hwdata <= d;
        phase();
        q = hrdata;
        `CHK("hresp", 1'h0, hresp)
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, idx, d, q);
    endtask
    task automatic tick(input logic [2:0] b);
        {wt, ct, st} <= b;
        @(posedge hclk);
        {wt, ct, st} <= 3'h0;
        @(posedge hclk);
    endtask

    // ****************************************************
    // sleep entry and wake with oscillator type t
    // ****************************************************
    task automatic sleep_wake(input int t);
        int n;
        seed = lfsr(seed);
        wr(OSC_CFG_IDX, t);
        wr(PB_WAKE_MASK_IDX, (seed & 32'h7c) | 32'h1);
        wr(MODE_CTRL_IDX, 32'h1);
        cyc(3);
        osc_run <= 1'h0;
        tick(3'h4);
        port_b[1] <= ~port_b[1]; // masked pin, must not wake
        cyc(6);
        `CHK("sleep hold", 1'h0, cpu_run)
        bus(1'h0, MODE_CTRL_IDX, 32'h0, r);
        `CHK("sleep state", 32'h21, r)
        if (t == 2) port_a[0] <= 1'h0;
        else if (t % 2 == 1) port_b[0] <= ~port_b[0];
        else port_a[7] <= ~port_a[7];
        cyc(8);
        `CHK("no osc", 1'h0, cpu_run)
        bus(1'h0, MODE_CTRL_IDX, 32'h0, r);
        `CHK("warm state", 32'h40, r)
        osc_run <= 1'h1;
        n = 0;
        while (cpu_run !== 1'h1 && n < 4000) begin cyc(1); n++; end
        if (n >= 4000) begin errors++; end_of_test(); end
        `CHK("warm len", 1'h1, n >= warm(t) - 8 && n <= warm(t) + 16)
        bus(1'h0, MODE_CTRL_IDX, 32'h0, r);
        `CHK("mode", 32'h0, r)
        bus(1'h0, IRQ_FLAGS_IDX, 32'h0, r);
        if (t == 2) `CHK("line a flag", 1'h1, r[0])
        wr(IRQ_FLAGS_IDX, 32'h0);
    endtask

    // ****************************************************
    // main sequence
    // ****************************************************
    logic [7:0] idx_t [5] = '{8'hc0, 8'hc9, 8'hc8, 8'hdf, 8'h10};
    logic [31:0] rst_t [5] = '{32'h0, 32'h0, 32'h0, 32'h7, 32'h0};
    initial begin
        cyc(4);
        hresetn <= 1'h1;
        cyc(1);
        wr(PB_WAKE_MASK_IDX, 32'h7f);
        for (int i = 0; i < 5; i++) begin
            bus(1'h0, idx_t[i], 32'h0, r);
            `CHK("reset value", rst_t[i], r)
        end
        seed = lfsr(seed);
        wr(IRQ_EN_IDX, seed);
        bus(1'h0, IRQ_EN_IDX, 32'h0, r);
        `CHK("enables", seed & 32'h73, r)
        wr(IRQ_EN_IDX, 32'h20);
        tick(3'h7);
        cyc(3);
        `CHK("no gie", 1'h0, irq_pending)
        bus(1'h0, IRQ_FLAGS_IDX, 32'h0, r);
        `CHK("flags", 32'h70, r)
        lat <= seed[1:0];
        wr(STACK_PTR_IDX, 32'h87);
        for (int k = 0; k < 20 && vec_cnt !== 8'h01; k++) cyc(1);
        `CHK("vector", 8'h01, vec_cnt)
        wr(IRQ_FLAGS_IDX, 32'h0);
        bus(1'h0, STACK_PTR_IDX, 32'h0, r);
        `CHK("entry stack", 32'h06, r)
        ret <= 1'h1;
        cyc(1);
        ret <= 1'h0;
        cyc(3);
        bus(1'h0, STACK_PTR_IDX, 32'h0, r);
        `CHK("return stack", 32'h87, r)
        for (int t = 0; t < 5; t++) sleep_wake(t);
        wr(MODE_CTRL_IDX, 32'h6);
        cyc(3);
        `CHK("idle hold", 1'h0, cpu_run)
        tick(3'h4);
        cyc(1);
        `CHK("idle wake", 1'h1, cpu_run)
        `CHK("slow kept", 1'h1, cpu_slow)
        bus(1'h0, MODE_CTRL_IDX, 32'h0, r);
        `CHK("idle mode", 32'h14, r)
        end_of_test();
    end
endmodule
`default_nettype wire
